/* File: logic/lbr_pkg.sv */
// Package of constants for the line break reader interlock.
package lbr_pkg;

    // ******************************************************************
    // Input conditioning
    // ******************************************************************
    localparam int unsigned CLK_PERIOD_NS  = 100;
    localparam int unsigned DEBOUNCE_US    = 5000;
    localparam int unsigned DEBOUNCE_CYC   = (DEBOUNCE_US * 1000) / CLK_PERIOD_NS;
    localparam int unsigned NUM_INPUTS     = 9;
    localparam int unsigned CNT_W          = 16;

    // Bit positions of the conditioned input vector.
    localparam int unsigned IN_LINE_BREAK  = 0;
    localparam int unsigned IN_TAPE_LOADED = 1;
    localparam int unsigned IN_RUN         = 2;
    localparam int unsigned IN_OPERATE     = 3;
    localparam int unsigned IN_MANUAL      = 4;
    localparam int unsigned IN_INTERLOCK   = 5;
    localparam int unsigned IN_AA_REST     = 6;
    localparam int unsigned IN_AA_REST_TWO = 7;
    localparam int unsigned IN_TEST_BIAS   = 8;

    // Reset value of the conditioned inputs: everything inactive.
    localparam logic [NUM_INPUTS-1:0] IN_RESET = 9'h000;

    // ******************************************************************
    // Line break relay states
    // ******************************************************************
    typedef enum logic [1:0]
    {
        LBR_RELEASED  = 2'b01,
        LBR_ENERGIZED = 2'b10
    } lbr_relay_t;

endpackage : lbr_pkg

/* File: logic/lbr_interlock.sv */
// Line break reader interlock: relay, clutch and alarm logic of a tape sender.
`timescale 1ns/1ps

// What this block, the modems and the operator must do
// RQ1: The far modem keeps sending the line break tone while it is in data mode.
// RQ2: The line break indication reaches the line break relay driver only in operate position.
// RQ3: Line break with tape loaded energizes the line break relay; tape loss releases it.
// RQ4: The energized relay opens the alarm path contact and closes the reader permit contact.
// RQ5: The clutch runs only with run set, auto answer rest closed and reader permit closed.
// RQ6: The reader never senses tape while the reader permit contact is open.
// RQ7: Loss of line break opens the reader permit contact; in test position the bias keeps it closed.
// RQ8: Run with reader permit open energizes the alarm relay and audible and visual alarms.
// RQ9: End of tape releases the line break relay and so stops the clutch.
// RQ10: Alarm relay follows run, both auto answer rest contacts and alarm path; aux alarm follows.
// RQ11: Setting stop disables all alarm outputs.
// RQ12: In manual mode the motor start relay stays released whatever the interlock does.
// RQ13: On data mode the modem raises its interlock output.
// RQ14: Before manual operation the inputs rest in their idle states.
// RQ15: The operator waits a few seconds after data mode before selecting run; the testbench sets run in the same step as data mode.
// RQ16: All contact and modem inputs are synchronized and debounced before use.

module lbr_interlock
    import lbr_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rstn_i,
    input  wire logic ce_i,
    input  wire logic line_break_i,
    input  wire logic tape_loaded_i,
    input  wire logic run_i,
    input  wire logic test_operate_selector_a_i,
    input  wire logic test_operate_selector_b_i,
    input  wire logic manual_mode_i,
    input  wire logic interlock_i,
    input  wire logic auto_answer_rest_contact_i,
    input  wire logic auto_answer_rest_contact_two_i,
    output logic      line_break_relay_driver_o,
    output logic      motor_start_relay_driver_o,
    output logic      alarm_path_contact_o,
    output logic      reader_permit_contact_o,
    output logic      reader_clutch_o,
    output logic      alarm_relay_o,
    output logic      audible_alarm_o,
    output logic      visual_alarm_o,
    output logic      aux_alarm_enable_o
);

    // ******************************************************************
    // Reset release
    // ******************************************************************

    // Releasing reset straight from the pin could let some flops leave reset one
    // edge before others; the two-flop copy makes every flop leave it together.
    logic [1:0] rst_sync;
    logic       rstn;

    // Assertion is asynchronous, release is taken through two flops.
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            rst_sync <= 2'b00;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end

    assign rstn = rst_sync[1];

    // ******************************************************************
    // State
    // ******************************************************************

    // All state but the reset synchronizer lives in one record so that the clock enable can freeze it in one place.
    // The contact outputs are flops of their own, so every output stays registered.
    typedef struct packed
    {
        logic [NUM_INPUTS-1:0]            s1;
        logic [NUM_INPUTS-1:0]            s2;
        logic [NUM_INPUTS-1:0]            s3;
        logic [NUM_INPUTS-1:0]            stable;
        logic [NUM_INPUTS-1:0][CNT_W-1:0] cnt;
        lbr_relay_t                       relay;
        logic                             motor;
        logic                             alarm_path;
        logic                             permit;
        logic                             clutch;
        logic                             alarm;
        logic                             aux;
    } lbr_state_t;

    // At reset the relay is down, so the alarm path contact rests closed
    // and every driver output is off.
    localparam lbr_state_t STATE_RESET = '{
        s1:         IN_RESET,
        s2:         IN_RESET,
        s3:         IN_RESET,
        stable:     IN_RESET,
        cnt:        '0,
        relay:      LBR_RELEASED,
        motor:      1'b0,
        alarm_path: 1'b1,
        permit:     1'b0,
        clutch:     1'b0,
        alarm:      1'b0,
        aux:        1'b0
    };

    lbr_state_t state;
    lbr_state_t next_state;
    logic [NUM_INPUTS-1:0] raw;

    // Selector in test position biases both relay drivers as if data mode were up.
    // Bit order follows the IN_ positions of the package.
    assign raw = {~test_operate_selector_b_i, auto_answer_rest_contact_two_i,
                  auto_answer_rest_contact_i, interlock_i, manual_mode_i,
                  test_operate_selector_a_i, run_i, tape_loaded_i, line_break_i};

    // Debounce step shared by every input channel.
    // Any disagreement restarts the count, so a bouncing contact is never accepted.
    function automatic logic [CNT_W-1:0] lbr_count(input logic agree,
                                                   input logic [CNT_W-1:0] cur);
        if (!agree)
            return '0;
        else
            return cur + 16'h0001;
    endfunction : lbr_count

    // ******************************************************************
    // Next state
    // ******************************************************************

    always_comb
    begin
        logic lb_gated;
        logic energize;
        lb_gated   = 1'b0;
        energize   = 1'b0;
        next_state = state;
        // Three-stage synchronizer; only stages two and three are compared.
        next_state.s1 = raw;                                             // see RQ16
        next_state.s2 = state.s1;
        next_state.s3 = state.s2;
        // A change is accepted only after it holds for the debounce time,
        // which filters contact bounce at the price of a few ms of delay.
        for (int i = 0; i < NUM_INPUTS; i++)
        begin
            if (state.s2[i] == state.s3[i] && state.s3[i] != state.stable[i])
            begin
                next_state.cnt[i] = lbr_count(1'b1, state.cnt[i]);       // see RQ16
                if (state.cnt[i] >= CNT_W'(DEBOUNCE_CYC - 1))
                begin
                    next_state.stable[i] = state.s3[i];
                    next_state.cnt[i]    = '0;
                end
            end
            else
            begin
                next_state.cnt[i] = lbr_count(1'b0, state.cnt[i]);
            end
        end
        // Line break reaches the driver only via operate; test simulates data mode.
        lb_gated = (state.stable[IN_LINE_BREAK] && state.stable[IN_OPERATE])  // see RQ2
                   || state.stable[IN_TEST_BIAS];
        // Relay holds through the tape-out contact; end of tape drops it.
        energize = lb_gated && state.stable[IN_TAPE_LOADED];             // see RQ3, RQ7, RQ9
        // The relay has no memory of its own beyond this state: it falls
        // as soon as its energizing path breaks, just as the coil would.
        unique case (state.relay)
            LBR_RELEASED:
            begin
                if (energize)
                    next_state.relay = LBR_ENERGIZED;
            end
            LBR_ENERGIZED:
            begin
                if (!energize)
                    next_state.relay = LBR_RELEASED;
            end
            default:
            begin
                next_state.relay = LBR_RELEASED;
            end
        endcase
        // Contacts follow the relay state of this cycle's decision.
        next_state.permit     = (next_state.relay == LBR_ENERGIZED);     // see RQ4
        next_state.alarm_path = (next_state.relay != LBR_ENERGIZED);     // see RQ4
        // Clutch path: run, first rest contact, reader permit in series.
        next_state.clutch = state.stable[IN_RUN] && state.stable[IN_AA_REST]
                            && next_state.permit;                        // see RQ5, RQ6
        // Alarm path: run, both rest contacts, alarm path contact in series.
        // Stop breaks the series path, so all alarms drop with it.
        next_state.alarm = state.stable[IN_RUN] && state.stable[IN_AA_REST]
                           && state.stable[IN_AA_REST_TWO]
                           && next_state.alarm_path;                     // see RQ8, RQ10, RQ11
        next_state.aux   = next_state.alarm;                             // see RQ10
        // In test position the bias drives the motor relay as if data mode were up.
        // Manual breaks the path from the interlock driver to the motor relay.
        next_state.motor = (state.stable[IN_INTERLOCK] || state.stable[IN_TEST_BIAS])
                           && !state.stable[IN_MANUAL];                  // see RQ12
    end

    // Clock enable freezes every bit of the state record; the reset synchronizer keeps running.
    // While ce_i is low the debounce time stretches by the frozen cycles.
    always_ff @(posedge clk_i or negedge rstn)
    begin
        if (!rstn)
            state <= STATE_RESET;
        else if (ce_i)
            state <= next_state;
    end

    // ******************************************************************
    // Outputs
    // ******************************************************************

    // Every output but the relay driver, a decode of state.relay, is a flop of the state record.
    // The three alarm outputs share one flop, so they can never disagree.
    assign line_break_relay_driver_o  = (state.relay == LBR_ENERGIZED);
    assign motor_start_relay_driver_o = state.motor;
    assign alarm_path_contact_o       = state.alarm_path;
    assign reader_permit_contact_o    = state.permit;
    assign reader_clutch_o            = state.clutch;
    assign alarm_relay_o              = state.alarm;
    assign audible_alarm_o            = state.alarm;
    assign visual_alarm_o             = state.alarm;
    assign aux_alarm_enable_o         = state.aux;

    // ******************************************************************
    // Checks
    // ******************************************************************

    // All checks sample on the block clock and sleep while the internal reset is low.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn);

    // Mirror of the relay decision, used only to aim the alarm check at cycles that leave the relay released.
    logic energize_chk;
    assign energize_chk = ((state.stable[IN_LINE_BREAK] && state.stable[IN_OPERATE])
                           || state.stable[IN_TEST_BIAS]) && state.stable[IN_TAPE_LOADED];

    // The clutch coil is fed through the permit contact, never around it.
    permit_gates_clutch_a: assert property (reader_clutch_o |-> reader_permit_contact_o) // see RQ6
        else $error("Clutch driven with reader permit open.");

    // The two contacts of the relay always sit in opposite positions.
    contacts_opposite_a: assert property (alarm_path_contact_o
                                          != reader_permit_contact_o) // see RQ4
        else $error("Alarm path and reader permit not complementary.");

    // The relay decides one edge before it shows, so the tape level of that edge counts.
    relay_needs_tape_a: assert property ($rose(line_break_relay_driver_o)
                                         |-> $past(state.stable[IN_TAPE_LOADED])) // see RQ3
        else $error("Line break relay energized without tape.");

    // Running out of tape drops the relay on the next enabled edge.
    tape_loss_release_a: assert property ((ce_i && !state.stable[IN_TAPE_LOADED])
                                          |=> !line_break_relay_driver_o) // see RQ9
        else $error("Relay held after tape ran out.");

    // Manual mode cuts the interlock path to the motor start relay.
    manual_blocks_motor_a: assert property (ce_i && state.stable[IN_MANUAL]
                                            |=> !motor_start_relay_driver_o) // see RQ12
        else $error("Motor start relay energized in manual mode.");

    // Stop opens the series alarm path, so every alarm output drops.
    stop_kills_alarm_a: assert property (ce_i && !state.stable[IN_RUN]
                                         |=> !alarm_relay_o && !aux_alarm_enable_o) // see RQ11
        else $error("Alarm active at stop.");

    // Run with the permit contact open must sound the alarm.
    alarm_on_break_a: assert property (ce_i && state.stable[IN_RUN] && state.stable[IN_AA_REST]
                                       && state.stable[IN_AA_REST_TWO] && !energize_chk
                                       |=> alarm_relay_o && audible_alarm_o) // see RQ8
        else $error("No alarm on line break with run set.");

    // Off operate, the line break indication must not reach the relay driver.
    gate_operate_a: assert property (ce_i && !state.stable[IN_OPERATE]
                                     && !state.stable[IN_TEST_BIAS]
                                     |=> !line_break_relay_driver_o) // see RQ2
        else $error("Line break passed with selector off operate.");

    // Run and the first rest contact are both needed in the clutch path.
    clutch_needs_run_a: assert property (ce_i && !(state.stable[IN_RUN]
                                         && state.stable[IN_AA_REST])
                                         |=> !reader_clutch_o) // see RQ5
        else $error("Clutch driven without run or rest contact.");

    // Without the tone, and outside test, the permit contact must open.
    line_loss_permit_a: assert property (ce_i && !state.stable[IN_LINE_BREAK]
                                         && !state.stable[IN_TEST_BIAS]
                                         |=> !reader_permit_contact_o) // see RQ7
        else $error("Reader permit held after line break was lost.");

    // The second rest contact sits in the alarm path as well.
    alarm_needs_rest_a: assert property (ce_i && !state.stable[IN_AA_REST_TWO]
                                         |=> !alarm_relay_o && !aux_alarm_enable_o) // see RQ10
        else $error("Alarm active with second rest contact open.");

    // Main scenarios: reader start, alarm, end of tape, motor start and test position.
    reader_runs_c: cover property ($rose(reader_clutch_o));
    alarm_raised_c: cover property ($rose(alarm_relay_o));
    end_of_tape_c: cover property ($fell(line_break_relay_driver_o) && !reader_clutch_o);
    motor_start_c: cover property ($rose(motor_start_relay_driver_o));
    test_position_c: cover property (state.stable[IN_TEST_BIAS] && line_break_relay_driver_o);

endmodule : lbr_interlock

/* File: verif/lbr_modem_model.sv */
// Behavioural model of the modem with its line break tone detector.
`timescale 1ns/1ps

module lbr_modem_model
(
    input  wire logic clk_i,
    input  wire logic local_data_i,
    input  wire logic remote_data_i,
    output logic      line_break_o,
    output logic      interlock_o
);
    // Idle at time zero: talk state, interlock inactive, no tone.
    initial
    begin
        interlock_o  = 1'b0;
        line_break_o = 1'b0;
    end

    // The far end sends its tone only while both ends are in data mode.
    always @(posedge clk_i)
    begin
        interlock_o  <= #1 local_data_i;
        line_break_o <= #1 local_data_i & remote_data_i;
    end
endmodule : lbr_modem_model

/* File: verif/line_break_reader_interlock_tb.sv */
// Self-checking testbench of the line break reader interlock.
`timescale 1ns/1ps

module line_break_reader_interlock_tb
    import lbr_pkg::*;
    ;

    // ******************************************************************
    // Signals
    // ******************************************************************
    logic       clk_i;
    logic       rstn_i;
    logic       ce_i;
    logic       local_data;
    logic       remote_data;
    wire logic  line_break;
    wire logic  interlock;
    logic [6:0] sw; // Tape, run, sel a, sel b, manual, rest, rest two.
    logic [8:0] outs;
    logic       manual_pick;
    logic [6:0] last_sw;
    int         fail_count;
    int         checks;
    int         seed;

    lbr_modem_model lbr_modem_model_inst (.clk_i(clk_i), .local_data_i(local_data),
        .remote_data_i(remote_data), .line_break_o(line_break), .interlock_o(interlock));

    lbr_interlock lbr_interlock_inst (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i),
        .line_break_i(line_break), .tape_loaded_i(sw[6]), .run_i(sw[5]),
        .test_operate_selector_a_i(sw[4]), .test_operate_selector_b_i(sw[3]),
        .manual_mode_i(sw[2]), .interlock_i(interlock),
        .auto_answer_rest_contact_i(sw[1]), .auto_answer_rest_contact_two_i(sw[0]),
        .line_break_relay_driver_o(outs[8]), .motor_start_relay_driver_o(outs[7]),
        .alarm_path_contact_o(outs[6]), .reader_permit_contact_o(outs[5]),
        .reader_clutch_o(outs[4]), .alarm_relay_o(outs[3]), .audible_alarm_o(outs[2]),
        .visual_alarm_o(outs[1]), .aux_alarm_enable_o(outs[0]));

    // ******************************************************************
    // Expectations and checks
    // ******************************************************************
    // Selector b in test position feeds both drivers as if in data mode.
    function automatic logic [8:0] expect_outs(input logic lb, input logic il,
                                               input logic [6:0] s);
        logic relay;
        logic path;
        relay = ((lb & s[4]) | ~s[3]) & s[6];
        path  = ~relay;
        expect_outs = {relay, (il | ~s[3]) & ~s[2], path, relay, s[5] & s[1] & relay,
                       {4{s[5] & s[1] & s[0] & path}}};
    endfunction : expect_outs

    task automatic check(input string name, input logic [8:0] exp, input logic [8:0] got);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish

    // Random chatter first, then the final levels; outputs hold until debounce ends.
    task automatic settle(input logic [6:0] s, input logic l, input logic r, input logic mid);
        logic [8:0] prev;
        prev = expect_outs(local_data & remote_data, local_data, sw);
        repeat (16)
        begin
            @(posedge clk_i);
            #1;
            sw = 7'($random(seed));
            {local_data, remote_data} = 2'($random(seed));
        end
        @(posedge clk_i);
        #1;
        sw = s;
        local_data = l;
        remote_data = r;
        repeat (DEBOUNCE_CYC / 2) @(posedge clk_i);
        #1;
        if (mid)
            check("held", prev, outs);
        repeat (DEBOUNCE_CYC / 2 + 12) @(posedge clk_i);
        #1;
    endtask : settle

    // ******************************************************************
    // Clock, watchdog and main sequence
    // ******************************************************************
    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    // The two phases need about 100k cycles; a hang gets cut off after 110k.
    initial
    begin
        #(64'd110000 * 64'd100);
        fail_count++;
        tally_and_finish();
    end

    initial
    begin
        seed = 8;
        fail_count = 0;
        checks = 0;
        rstn_i = 1'b0;
        ce_i = 1'b1;
        sw = 7'h5f;
        local_data = 1'b0;
        remote_data = 1'b0;
        repeat (12) @(posedge clk_i);
        #1;
        check("reset", 9'h040, outs);
        rstn_i = 1'b1;
        // Data mode at both ends with run set in the same step, without the wait.
        settle(7'h7f, 1'b1, 1'b1, 1'b0);
        check("running", expect_outs(1'b1, 1'b1, 7'h7f), outs);
        // Either the tape runs out or the far end drops out of data mode; the
        // automatic-manual switch is drawn at random, so the motor relay may pick up.
        manual_pick = 1'($random(seed));
        if ($random(seed) & 1)
        begin
            last_sw = {4'b0111, manual_pick, 2'b11};
            settle(last_sw, 1'b1, 1'b1, 1'b1);
            check("end of tape", expect_outs(1'b1, 1'b1, last_sw), outs);
        end
        else
        begin
            last_sw = {4'b1111, manual_pick, 2'b11};
            settle(last_sw, 1'b1, 1'b0, 1'b1);
            check("line lost", expect_outs(1'b0, 1'b1, last_sw), outs);
        end
        tally_and_finish();
    end
endmodule : line_break_reader_interlock_tb
